// *** common/pmu_map.vh ***
// register map, field positions, reset values and timing constants of the sleep/wake controller
//
// Functional notes
// - wake pin select bit 0 enables port 0 pin 14, bit 1 port 1 pin 4
// - wake active level bit per pin: zero active high, one active low
// - hibernation bit clear gives deep sleep with sleep domain on, set turns it off
// - fast wake bit enables all regulators together instead of staggered
// - regulator wait skip replaces regulator good wait with a fixed 32 us timeout
// - brownout comparators must report good before active, even when wait is skipped
// - skip bit lets a fast wake reach running without waiting for reference good
// - mask bit, reset one, suppresses brownout reset while reference is not good
// - keep-on bit holds the voltage reference enabled throughout deep sleep
// - reference refreshed every 12-bit period of low power clock ticks over 64
`ifndef PMU_MAP_VH
`define PMU_MAP_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define ADDR_SUPPLY_LVL 32'h500000e4
`define ADDR_HIBERN 32'h500000f0
`define ADDR_SLEEP_SEQ 32'h050000f4
`define ADDR_STATUS 32'h50000180

// ************************************************************
// field positions
// ************************************************************
`define HIB_ENABLE_BIT 0
`define WAKE_LVL_LSB 2
`define WAKE_SEL_LSB 4
`define FAST_WAKE_BIT 16
`define REG_WAIT_SKIP_BIT 15
`define REF_WAIT_SKIP_BIT 14
`define BOD_MASK_BIT 13
`define REF_KEEP_BIT 12
`define REFRESH_MSB 11

// ************************************************************
// reset values and writable masks
// ************************************************************
`define RST_SUPPLY_LVL 32'h00000000
`define RST_HIBERN 32'h00000000
`define RST_SLEEP_SEQ 32'h00002080
`define MASK_HIBERN 32'h0000003f
`define MASK_SLEEP_SEQ 32'h0001ffff

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ 125
`define REG_OK_TIMEOUT_US 32
`define LP_DIV 64

`endif

// *** logic/reference_refresh_timer.v ***
// periodic voltage reference refresh timer on low power clock ticks
`timescale 1ns/1ps
`include "pmu_map.vh"
module reference_refresh_timer #(
   parameter ON_CYCLES = 16
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire run,
   input wire lp_tick,
   input wire [11:0] period,
   output reg refresh_r
);
   localparam [31:0] DIV_LAST_W = `LP_DIV - 1;
   localparam [31:0] ON_LAST_W = ON_CYCLES - 1;
   localparam [5:0] DIV_LAST = DIV_LAST_W[5:0];
   localparam [7:0] ON_LAST = ON_LAST_W[7:0];
   reg [5:0] div_r;
   reg [11:0] period_cnt_r;
   reg [7:0] on_cnt_r;

   always @(posedge clk) begin
      if (rst || (ce && !run)) begin
         div_r <= 6'h00;
         period_cnt_r <= 12'h000;
         on_cnt_r <= 8'h00;
         refresh_r <= 1'b0;
      end else if (ce) begin
         if (refresh_r) begin
            if (on_cnt_r == ON_LAST) begin
               refresh_r <= 1'b0;
            end
            on_cnt_r <= on_cnt_r + 8'h01;
         end
         if (lp_tick) begin
            if (div_r == DIV_LAST) begin
               div_r <= 6'h00;
               // one divided tick elapsed; period counted in these
               if (period_cnt_r + 12'h001 >= period) begin
                  period_cnt_r <= 12'h000;
                  refresh_r <= 1'b1;
                  on_cnt_r <= 8'h00;
               end else begin
                  period_cnt_r <= period_cnt_r + 12'h001;
               end
            end else begin
               div_r <= div_r + 6'h01;
            end
         end
      end
   end
endmodule

// *** logic/sleep_wakeup_power_control.v ***
// sleep, hibernation and wake-up sequencer with its register file
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "pmu_map.vh"
module sleep_wakeup_power_control #(
   parameter NUM_REGS = 4,
   parameter STAGGER_CYCLES = 8,
   parameter REFRESH_ON_CYCLES = 16
) (
   input wire SYS_CLK,
   input wire RST,
   input wire CE,
   input wire [31:0] ADDR,
   input wire [31:0] WR_DATA,
   input wire WR_STB,
   input wire RD_STB,
   output reg [31:0] RD_DATA,
   input wire SLEEP_REQ,
   input wire WAKE_EVENT,
   input wire WAKE_PIN_P0_14,
   input wire WAKE_PIN_P1_4,
   input wire [NUM_REGS-1:0] REGULATOR_GOOD,
   input wire BROWNOUT_GOOD,
   input wire BROWNOUT_EVENT,
   input wire REFERENCE_GOOD,
   input wire LOW_POWER_CLOCK_TICK,
   output reg [NUM_REGS-1:0] REGULATOR_EN,
   output reg SLEEP_POWER_DOMAIN_ON,
   output reg VOLTAGE_REFERENCE_EN,
   output reg BROWNOUT_RESET,
   output reg RUNNING,
   output reg HIBERNATING
);
   // ************************************************************
   // constants
   // ************************************************************
   localparam [2:0] S_ACTIVE = 3'd0;
   localparam [2:0] S_SLEEP = 3'd1;
   localparam [2:0] S_STAGGER = 3'd2;
   localparam [2:0] S_WAIT_OK = 3'd3;
   localparam [2:0] S_BOD = 3'd4;
   localparam [2:0] S_REF = 3'd5;
   localparam [31:0] REG_OK_CYCLES = `REG_OK_TIMEOUT_US * `CLK_MHZ;
   localparam [31:0] REG_OK_LAST_W = REG_OK_CYCLES - 1;
   localparam [31:0] STAGGER_LAST_W = STAGGER_CYCLES - 1;
   localparam [11:0] REG_OK_LAST = REG_OK_LAST_W[11:0];
   localparam [7:0] STAGGER_LAST = STAGGER_LAST_W[7:0];
   localparam [NUM_REGS-1:0] ALL_REGS = {NUM_REGS{1'b1}};
   localparam [NUM_REGS-1:0] NO_REGS = {NUM_REGS{1'b0}};

   // ************************************************************
   // registers
   // ************************************************************
   reg [31:0] supply_level_control_r;
   reg [31:0] hibernation_control_r;
   reg [31:0] sleep_sequencer_control_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg hib_latched_r;
   reg fast_latched_r;
   reg [11:0] wait_cnt_r;
   reg [7:0] stagger_cnt_r;
   wire refresh_pulse;

   wire hib_enable = hibernation_control_r[`HIB_ENABLE_BIT];
   wire [1:0] wake_pin_active_level = hibernation_control_r[`WAKE_LVL_LSB+1:`WAKE_LVL_LSB];
   wire [1:0] wake_pin_select = hibernation_control_r[`WAKE_SEL_LSB+1:`WAKE_SEL_LSB];
   wire fast_wake = sleep_sequencer_control_r[`FAST_WAKE_BIT];
   wire regulator_good_wait_skip = sleep_sequencer_control_r[`REG_WAIT_SKIP_BIT];
   wire quick_wake_reference_wait_skip = sleep_sequencer_control_r[`REF_WAIT_SKIP_BIT];
   wire brownout_reset_mask_on_bad_reference = sleep_sequencer_control_r[`BOD_MASK_BIT];
   wire reference_keep_on_in_sleep = sleep_sequencer_control_r[`REF_KEEP_BIT];
   wire [11:0] reference_refresh_period = sleep_sequencer_control_r[`REFRESH_MSB:0];

   // ************************************************************
   // wake pin qualification
   // ************************************************************
   wire [1:0] pin_raw = {WAKE_PIN_P1_4, WAKE_PIN_P0_14};
   // a level bit of one inverts the pin so that low counts as active
   wire [1:0] pin_active = pin_raw ^ wake_pin_active_level;
   // unselected pins never wake
   wire pin_wake = |(pin_active & wake_pin_select);
   // hibernation wakes from pins only, deep sleep from the wake event
   wire wake_now = hib_latched_r ? pin_wake : WAKE_EVENT;

   wire all_regs_good = &REGULATOR_GOOD;
   wire reg_timeout = (wait_cnt_r == REG_OK_LAST);
   wire stagger_step = (stagger_cnt_r == STAGGER_LAST);
   wire refresh_run = (state_r == S_SLEEP) && !hib_latched_r && !reference_keep_on_in_sleep;
   // entry edge uses the live bit, later sleep cycles the latched one
   wire sleep_as_hib = (state_r == S_ACTIVE) ? hib_enable : hib_latched_r;

   // ************************************************************
   // register bus
   // ************************************************************
   always @(posedge SYS_CLK) begin
      if (RST) begin
         supply_level_control_r <= `RST_SUPPLY_LVL;
         hibernation_control_r <= `RST_HIBERN;
         sleep_sequencer_control_r <= `RST_SLEEP_SEQ;
         RD_DATA <= 32'h00000000;
      end else if (CE) begin
         if (WR_STB) begin
            case (ADDR)
               `ADDR_SUPPLY_LVL: begin
                  supply_level_control_r <= WR_DATA;
               end
               `ADDR_HIBERN: begin
                  hibernation_control_r <= WR_DATA & `MASK_HIBERN;
               end
               `ADDR_SLEEP_SEQ: begin
                  sleep_sequencer_control_r <= WR_DATA & `MASK_SLEEP_SEQ;
               end
               default: begin
               end
            endcase
         end
         if (RD_STB) begin
            case (ADDR)
               `ADDR_SUPPLY_LVL: begin
                  RD_DATA <= supply_level_control_r;
               end
               `ADDR_HIBERN: begin
                  RD_DATA <= hibernation_control_r;
               end
               `ADDR_SLEEP_SEQ: begin
                  RD_DATA <= sleep_sequencer_control_r;
               end
               `ADDR_STATUS: begin
                  RD_DATA <= {16'h0000, REGULATOR_EN[NUM_REGS-1:0], {(8-NUM_REGS){1'b0}},
                              BROWNOUT_RESET, VOLTAGE_REFERENCE_EN, SLEEP_POWER_DOMAIN_ON,
                              HIBERNATING, RUNNING, state_r};
               end
               default: begin
                  RD_DATA <= 32'h00000000;
               end
            endcase
         end else begin
            RD_DATA <= 32'h00000000;
         end
      end
   end

   // ************************************************************
   // sequencer next state
   // ************************************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_ACTIVE: begin
            if (SLEEP_REQ) begin
               state_nxt = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (wake_now) begin
               // fast wake skips the staggered ramp
               state_nxt = fast_wake ? S_WAIT_OK : S_STAGGER;
            end
         end
         S_STAGGER: begin
            if (stagger_step && (REGULATOR_EN == ALL_REGS)) begin
               state_nxt = S_WAIT_OK;
            end
         end
         S_WAIT_OK: begin
            if (regulator_good_wait_skip) begin
               // fixed timeout replaces the regulator good wait
               if (reg_timeout) begin
                  state_nxt = S_BOD;
               end
            end else if (all_regs_good) begin
               state_nxt = S_BOD;
            end
         end
         S_BOD: begin
            // brownout check is never bypassed
            if (BROWNOUT_GOOD) begin
               if (fast_latched_r && quick_wake_reference_wait_skip) begin
                  state_nxt = S_ACTIVE;
               end else begin
                  state_nxt = S_REF;
               end
            end
         end
         S_REF: begin
            if (REFERENCE_GOOD) begin
               state_nxt = S_ACTIVE;
            end
         end
         default: begin
            state_nxt = S_ACTIVE;
         end
      endcase
   end

   // ************************************************************
   // sequencer state and counters
   // ************************************************************
   always @(posedge SYS_CLK) begin
      if (RST) begin
         state_r <= S_ACTIVE;
         hib_latched_r <= 1'b0;
         fast_latched_r <= 1'b0;
         wait_cnt_r <= 12'h000;
         stagger_cnt_r <= 8'h00;
      end else if (CE) begin
         state_r <= state_nxt;
         if (state_r == S_ACTIVE && SLEEP_REQ) begin
            // mode chosen at sleep entry
            hib_latched_r <= hib_enable;
         end
         if (state_r == S_SLEEP && wake_now) begin
            fast_latched_r <= fast_wake;
         end
         if (state_r == S_WAIT_OK) begin
            wait_cnt_r <= wait_cnt_r + 12'h001;
         end else begin
            wait_cnt_r <= 12'h000;
         end
         if (state_r == S_STAGGER && !stagger_step) begin
            stagger_cnt_r <= stagger_cnt_r + 8'h01;
         end else begin
            stagger_cnt_r <= 8'h00;
         end
      end
   end

   // ************************************************************
   // power outputs
   // ************************************************************
   always @(posedge SYS_CLK) begin
      if (RST) begin
         REGULATOR_EN <= ALL_REGS;
         SLEEP_POWER_DOMAIN_ON <= 1'b1;
         VOLTAGE_REFERENCE_EN <= 1'b1;
         RUNNING <= 1'b1;
         HIBERNATING <= 1'b0;
      end else if (CE) begin
         RUNNING <= (state_nxt == S_ACTIVE);
         HIBERNATING <= (state_nxt == S_SLEEP) && sleep_as_hib;
         case (state_nxt)
            S_SLEEP: begin
               REGULATOR_EN <= NO_REGS;
               if (state_r == S_ACTIVE) begin
                  // deep sleep keeps the domain, hibernation drops it
                  SLEEP_POWER_DOMAIN_ON <= !hib_enable;
               end
               if (sleep_as_hib) begin
                  VOLTAGE_REFERENCE_EN <= 1'b0;
               end else begin
                  // keep-on bit or periodic refresh
                  VOLTAGE_REFERENCE_EN <= reference_keep_on_in_sleep | refresh_pulse;
               end
            end
            S_STAGGER: begin
               SLEEP_POWER_DOMAIN_ON <= 1'b1;
               VOLTAGE_REFERENCE_EN <= 1'b1;
               if (state_r == S_SLEEP) begin
                  REGULATOR_EN <= {{(NUM_REGS-1){1'b0}}, 1'b1};
               end else if (stagger_step) begin
                  // one more regulator per step, in order
                  REGULATOR_EN <= {REGULATOR_EN[NUM_REGS-2:0], 1'b1};
               end
            end
            S_ACTIVE, S_WAIT_OK, S_BOD, S_REF: begin
               // all at once on fast wake, or after the ramp
               REGULATOR_EN <= ALL_REGS;
               SLEEP_POWER_DOMAIN_ON <= 1'b1;
               VOLTAGE_REFERENCE_EN <= 1'b1;
            end
            default: begin
               REGULATOR_EN <= ALL_REGS;
               SLEEP_POWER_DOMAIN_ON <= 1'b1;
               VOLTAGE_REFERENCE_EN <= 1'b1;
            end
         endcase
      end
   end

   // ************************************************************
   // brownout reset gating
   // ************************************************************
   always @(posedge SYS_CLK) begin
      if (RST) begin
         BROWNOUT_RESET <= 1'b0;
      end else if (CE) begin
         // suppressed while the reference is not good and masking is on
         BROWNOUT_RESET <= BROWNOUT_EVENT &
                           !(brownout_reset_mask_on_bad_reference && !REFERENCE_GOOD);
      end
   end

   // ************************************************************
   // reference refresh
   // ************************************************************
   reference_refresh_timer #(
      .ON_CYCLES(REFRESH_ON_CYCLES)
   ) u_refresh (
      .clk(SYS_CLK),
      .rst(RST),
      .ce(CE),
      .run(refresh_run),
      .lp_tick(LOW_POWER_CLOCK_TICK),
      .period(reference_refresh_period),
      .refresh_r(refresh_pulse)
   );
endmodule

// *** test/swpc_sva.sv ***
// port-level assertions for the sleep and wake sequencer
`timescale 1ns/1ps
`include "pmu_map.vh"
module swpc_sva #(
   parameter NUM_REGS = 4
) (
   input wire SYS_CLK,
   input wire RST,
   input wire CE,
   input wire [31:0] ADDR,
   input wire [31:0] WR_DATA,
   input wire WR_STB,
   input wire SLEEP_REQ,
   input wire WAKE_EVENT,
   input wire WAKE_PIN_P0_14,
   input wire WAKE_PIN_P1_4,
   input wire BROWNOUT_GOOD,
   input wire BROWNOUT_EVENT,
   input wire REFERENCE_GOOD,
   input wire [NUM_REGS-1:0] REGULATOR_EN,
   input wire SLEEP_POWER_DOMAIN_ON,
   input wire VOLTAGE_REFERENCE_EN,
   input wire BROWNOUT_RESET,
   input wire RUNNING,
   input wire HIBERNATING
);
   // ****
   // shadow fields and wake-up timer
   // ****
   reg [5:0] hib_r;
   reg [16:0] seq_r;
   reg [15:0] on_n_r;
   wire hit = (hib_r[4] & (WAKE_PIN_P0_14 ^ hib_r[2])) | (hib_r[5] & (WAKE_PIN_P1_4 ^ hib_r[3]));
   wire asleep = !RUNNING && REGULATOR_EN == 0;
   wire deep_wake = asleep && !HIBERNATING && WAKE_EVENT && CE;
   always @(posedge SYS_CLK) begin
      if (RST) begin
         hib_r <= 6'h00;
         seq_r <= 17'h02080;
      end else if (CE && WR_STB && ADDR == `ADDR_HIBERN) begin
         hib_r <= WR_DATA[5:0];
      end else if (CE && WR_STB && ADDR == `ADDR_SLEEP_SEQ) begin
         seq_r <= WR_DATA[16:0];
      end
      if (RST || !(&REGULATOR_EN)) begin
         on_n_r <= 16'h0000;
      end else if (on_n_r != 16'hffff) begin
         on_n_r <= on_n_r + 16'h0001;
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_sleep_mode: assert property (RUNNING && SLEEP_REQ && CE |=>
      SLEEP_POWER_DOMAIN_ON == !hib_r[0] && HIBERNATING == hib_r[0]) else $error("sleep mode");
   a_fast_all_on: assert property (deep_wake && seq_r[16] |=> &REGULATOR_EN)
      else $error("fast wake");
   a_stagger_steps: assert property (deep_wake && !seq_r[16] |=>
      REGULATOR_EN == 1 ##8 REGULATOR_EN == 3) else $error("stagger");
   a_pin_wake: assert property (HIBERNATING && hit && CE |=> REGULATOR_EN != 0)
      else $error("pin wake");
   a_pin_ignored: assert property (HIBERNATING && !hit && CE |=> HIBERNATING)
      else $error("stray wake");
   a_reg_timeout: assert property ($rose(RUNNING) && seq_r[15] |-> on_n_r >= 16'd4000)
      else $error("timeout short");
   a_bod_first: assert property ($rose(RUNNING) |-> $past(BROWNOUT_GOOD))
      else $error("brownout skipped");
   a_ref_wait: assert property ($rose(RUNNING) && !(seq_r[16] && seq_r[14]) |->
      $past(REFERENCE_GOOD)) else $error("reference skipped");
   a_keep_ref: assert property (asleep && SLEEP_POWER_DOMAIN_ON && seq_r[12] |->
      VOLTAGE_REFERENCE_EN) else $error("reference off");
   a_bod_gate: assert property (!$past(RST) |-> BROWNOUT_RESET ==
      $past(BROWNOUT_EVENT && !(seq_r[13] && !REFERENCE_GOOD))) else $error("brownout gate");
endmodule
bind sleep_wakeup_power_control swpc_sva #(.NUM_REGS(NUM_REGS)) chk_i (.*);

// *** test/analog_model.sv ***
// far-side model of regulator, brownout and reference status
`timescale 1ns/1ps
module analog_model (
   input wire clk,
   input wire [3:0] reg_en,
   input wire ref_en,
   input wire [8:0] lag,
   input wire ref_fault,
   input wire bod_fault,
   output logic [3:0] reg_good = 4'h0,
   output logic bod_good = 1'b0,
   output logic ref_good = 1'b0
);
   logic [8:0] up_r = 9'h000;
   // the reference reports good lag+1 cycles after its enable
   always @(posedge clk) begin
      reg_good <= reg_en;
      bod_good <= &reg_en && !bod_fault;
      up_r <= !ref_en ? 9'h000 : (up_r == 9'h1ff ? up_r : up_r + 9'h001);
      ref_good <= ref_en && up_r >= lag && !ref_fault;
   end
endmodule

// *** test/tb.sv ***
// self-checking bench for the sleep and wake sequencer
`timescale 1ns/1ps
`include "pmu_map.vh"
module tb;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, slp = 1'b0, wev = 1'b0;
   logic p0 = 1'b0, p1 = 1'b0, bev = 1'b0, tick = 1'b0, rfault = 1'b0, bfault = 1'b0;
   logic [8:0] lag = 9'h004;
   logic [31:0] addr = 32'h0, wdat = 32'h0, rdat;
   logic [3:0] ren, rgood;
   logic bgood, refg, refen, dom, bres, run, hib;
   int n_mismatch = 0, checks_done = 0, k;
   sleep_wakeup_power_control DUT (.SYS_CLK(clk), .RST(rst), .CE(ce), .ADDR(addr),
      .WR_DATA(wdat), .WR_STB(wr), .RD_STB(rd), .RD_DATA(rdat), .SLEEP_REQ(slp),
      .WAKE_EVENT(wev), .WAKE_PIN_P0_14(p0), .WAKE_PIN_P1_4(p1), .REGULATOR_GOOD(rgood),
      .BROWNOUT_GOOD(bgood), .BROWNOUT_EVENT(bev), .REFERENCE_GOOD(refg),
      .LOW_POWER_CLOCK_TICK(tick), .REGULATOR_EN(ren), .SLEEP_POWER_DOMAIN_ON(dom),
      .VOLTAGE_REFERENCE_EN(refen), .BROWNOUT_RESET(bres), .RUNNING(run), .HIBERNATING(hib));
   analog_model far (.clk(clk), .reg_en(ren), .ref_en(refen), .lag(lag), .ref_fault(rfault),
      .bod_fault(bfault), .reg_good(rgood), .bod_good(bgood), .ref_good(refg));
   initial forever #4 clk = ~clk;
   always @(posedge clk) tick <= ~tick;
   // ****
   // helpers
   // ****
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdat <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, exp);
   endtask
   task automatic pulse(input bit wake);
      @(posedge clk);
      if (wake) wev <= 1'b1;
      else slp <= 1'b1;
      @(posedge clk);
      wev <= 1'b0;
      slp <= 1'b0;
      #1;
   endtask
   task automatic wait_sig(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim) begin
         #8;
         n++;
      end
      chk(s, v);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs;
      rd_chk(`ADDR_HIBERN, 32'h0);
      rd_chk(`ADDR_SLEEP_SEQ, 32'h2080);
      rd_chk(`ADDR_SUPPLY_LVL, 32'h0);
      rd_chk(`ADDR_STATUS, 32'h0000f068);
      wr_reg(32'h50000100, 32'hffffffff);
      rd_chk(32'h50000100, 32'h0);
      wr_reg(`ADDR_HIBERN, 32'hffffffff);
      rd_chk(`ADDR_HIBERN, 32'h3f);
      wr_reg(`ADDR_SLEEP_SEQ, 32'hffffffff);
      rd_chk(`ADDR_SLEEP_SEQ, 32'h1ffff);
      wr_reg(`ADDR_SUPPLY_LVL, 32'h5a5a5a5a);
      rd_chk(`ADDR_SUPPLY_LVL, 32'h5a5a5a5a);
      wr_reg(`ADDR_HIBERN, 32'h0);
      chk(rdat, 32'h0);
   endtask
   task automatic t_deep;
      wr_reg(`ADDR_SLEEP_SEQ, 32'h1f080);
      pulse(0);
      chk({run, hib, dom, refen, ren}, 8'h30);
      cyc(50);
      chk(refen, 1'b1);
      pulse(1);
      chk(ren, 4'hf);
      wait_sig(run, 1'b1, 4100, k);
      chk(k > 3990 && k < 4010, 1'b1);
   endtask
   task automatic t_refwait;
      lag <= 9'd300;
      wr_reg(`ADDR_SLEEP_SEQ, 32'h16080);
      pulse(0);
      cyc(20);
      bfault <= 1'b1;
      pulse(1);
      cyc(10);
      chk(run, 1'b0);
      bfault <= 1'b0;
      wait_sig(run, 1'b1, 100, k);
      chk(refg, 1'b0);
      wr_reg(`ADDR_SLEEP_SEQ, 32'h12080);
      pulse(0);
      cyc(20);
      pulse(1);
      wait_sig(run, 1'b1, 900, k);
      chk(k >= 290, 1'b1);
      lag <= 9'h004;
   endtask
   task automatic t_stagger;
      wr_reg(`ADDR_SLEEP_SEQ, 32'h2080);
      pulse(0);
      pulse(1);
      chk(ren, 4'h1);
      cyc(8);
      chk(ren, 4'h3);
      wait_sig(run, 1'b1, 300, k);
   endtask
   task automatic t_hib;
      logic [5:0] cfg [4] = '{6'h11, 6'h29, 6'h15, 6'h31};
      for (int i = 0; i < 4; i++) begin
         wr_reg(`ADDR_HIBERN, {26'h0, cfg[i]});
         @(posedge clk);
         p0 <= cfg[i][2];
         p1 <= cfg[i][3];
         pulse(0);
         chk({hib, dom, refen}, 3'b100);
         @(posedge clk);
         p0 <= cfg[i][2] ^ !cfg[i][4];
         p1 <= cfg[i][3] ^ !cfg[i][5];
         pulse(1);
         cyc(4);
         chk(hib, 1'b1);
         @(posedge clk);
         if (i[0]) p1 <= !cfg[i][3];
         else p0 <= !cfg[i][2];
         cyc(2);
         chk(ren != 4'h0, 1'b1);
         wait_sig(run, 1'b1, 300, k);
      end
      wr_reg(`ADDR_HIBERN, 32'h0);
   endtask
   task automatic t_bod;
      @(posedge clk);
      bev <= 1'b1;
      cyc(2);
      chk(bres, 1'b1);
      rfault <= 1'b1;
      cyc(3);
      chk(bres, 1'b0);
      wr_reg(`ADDR_SLEEP_SEQ, 32'h0080);
      cyc(1);
      chk(bres, 1'b1);
      @(posedge clk);
      bev <= 1'b0;
      rfault <= 1'b0;
      #1;
   endtask
   task automatic t_refresh;
      wr_reg(`ADDR_SLEEP_SEQ, 32'h2);
      pulse(0);
      chk(refen, 1'b0);
      wait_sig(refen, 1'b1, 600, k);
      wait_sig(refen, 1'b0, 40, k);
      chk(k, 16);
      wait_sig(refen, 1'b1, 600, k);
      chk(k > 200 && k < 270, 1'b1);
      pulse(1);
      wait_sig(run, 1'b1, 300, k);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_regs;
      t_deep;
      t_refwait;
      t_stagger;
      t_hib;
      t_bod;
      t_refresh;
      print_verdict;
   end
endmodule
